/* File: digital_reset_controller.sv */
// Reset controller: turns the analog power-on reset into a tree of derived resets.
// Assumes REF_CLK runs whenever ANALOG_RESET falls and an Avalon-MM master
// holds each request until it samples AVS_WAITREQUEST low.
// Function
// R1 - The analog reset is active high and sets every internal reset at once, without a clock.
// R2 - Release of the analog reset passes a REF_CLK synchroniser so resets fall on a clock edge.
// R3 - The raw reset is the synchronised analog reset or the forced reset flop, low dips filtered.
// R4 - The raw reset clears the scan-control flops, which stay off the scan chain.
// R5 - The scan reset comes from three flops fed by the scan input under scan enable.
// R6 - The power-on reset is the raw reset, or the scan reset in scan mode, and feeds all others.
// R7 - The power-on reset doubles as the debug reset so debug and emulation state survive.
// R8 - Downstream logic needs only these synchronous resets, no asynchronous wiring.
// R9 - The debug-port reset is the power-on reset or the port-off or port-disabled flops.
// R10 - The debug FSM reset is the debug-port reset or the FSM request and touches only that FSM.
// R11 - The system reset is the power-on reset or the system request flop.
// R12 - The micro reset is the system reset or the micro request flop.
// R13 - The core reset is the micro reset or the core request flop, resetting only the core.
// R14 - The core request is masked while the secure boot routine is active.
// R15 - The core request stays masked one clock after the routine-active flag falls.
// R16 - In scan mode every derived reset is the scan reset; all are active high, with _N copies; only POR, SYS, MICRO and CORE have one.
// R17 - Every derived reset is registered so requests take effect glitch-free on the next edge.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rstc_cfg.svh"
module digital_reset_controller
(
	input  wire logic        REF_CLK,
	input  wire logic        RST_B,
	input  wire logic        ANALOG_RESET,
	input  wire logic        SCAN_EN,
	input  wire logic        SCAN_IN,
	input  wire logic        DEBUG_ACTIVE,
	input  wire logic        DEBUG_FSM_RESET_REQ,
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output var  logic [31:0] AVS_READDATA,
	output var  logic        AVS_WAITREQUEST,
	output var  logic        RAW_RST,
	output var  logic        SCAN_RST,
	output var  logic        POR_RST,
	output var  logic        DEBUG_PORT_RST,
	output var  logic        DEBUG_FSM_RST,
	output var  logic        SYS_RST,
	output var  logic        MICRO_RST,
	output var  logic        CORE_RST,
	output var  logic        POR_RST_N,
	output var  logic        SYS_RST_N,
	output var  logic        MICRO_RST_N,
	output var  logic        CORE_RST_N
);
	import rstc_pkg::*;

	logic        raw_sync;
	logic        scan_rst;
	logic        scan_mode;
	logic        debug_forced_por_flop_q;
	logic        debug_scan_mode_flop_q;
	logic        debug_port_off_flop_q;
	logic        debug_port_enable_flop_q;
	logic        debug_core_reset_req_q;
	logic        debug_micro_reset_req_q;
	logic        debug_system_reset_req_q;
	logic        active_q;
	logic        core_mask;
	rst_vec_t    rst_d;
	rst_vec_t    rst_q;
	logic [3:0]  rst_n_q;
	logic        waitreq_q;
	logic [31:0] readdata_q;
	logic        ctrl_wr;
	logic [7:0]  ctrl_word;
	logic [7:0]  ctrl_rst;
	logic [31:0] stat_word;

	function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] ofs);
		return addr == ofs;
	endfunction

	rst_deglitch_sync u_sync
	(
		.clk       (REF_CLK),
		.arst      (ANALOG_RESET),
		.force_rst (debug_forced_por_flop_q),
		.rst_out   (raw_sync)
	);

	scan_rst_gen u_scan
	(
		.clk      (REF_CLK),
		.raw_rst  (raw_sync),
		.scan_en  (SCAN_EN),
		.scan_in  (SCAN_IN),
		.scan_rst (scan_rst)
	);

	// Avalon slave: one wait state, accept on the edge where waitrequest is low
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_B)
			waitreq_q <= 1'b1;
		else
			waitreq_q <= !((AVS_READ || AVS_WRITE) && waitreq_q);
	end

	assign ctrl_wr = AVS_WRITE && !waitreq_q && AVS_BYTEENABLE[0]
		&& reg_hit(AVS_ADDRESS, `RSTC_CTRL_OFS);

	assign ctrl_word = {debug_scan_mode_flop_q, debug_system_reset_req_q,
		debug_micro_reset_req_q, debug_core_reset_req_q, 1'b0,
		debug_port_enable_flop_q, debug_port_off_flop_q, debug_forced_por_flop_q};

	assign stat_word = {22'h00_0000, debug_scan_mode_flop_q & SCAN_EN, active_q, rst_q};
	assign ctrl_rst  = `RSTC_CTRL_RST;

	// Unmapped addresses read as zero; writes to them are dropped
	always_ff @(posedge REF_CLK)
	begin
		if (!RST_B)
			readdata_q <= 32'h0000_0000;
		else if (AVS_READ && waitreq_q)
		begin
			if (reg_hit(AVS_ADDRESS, `RSTC_CTRL_OFS))
				readdata_q <= {24'h00_0000, ctrl_word};
			else if (reg_hit(AVS_ADDRESS, `RSTC_STAT_OFS))
				readdata_q <= stat_word;
			else
				readdata_q <= 32'h0000_0000;
		end
	end

	// Scan-control flops are cleared by the raw reset only, never by scan reset
	always_ff @(posedge REF_CLK)
	begin
		if (rst_q[IDX_RAW]) // R4
		begin
			debug_forced_por_flop_q <= ctrl_rst[`RSTC_CTRL_FPOR];
			debug_scan_mode_flop_q  <= ctrl_rst[`RSTC_CTRL_SCAN_MODE];
		end
		else if (ctrl_wr)
		begin
			debug_forced_por_flop_q <= AVS_WRITEDATA[`RSTC_CTRL_FPOR];
			debug_scan_mode_flop_q  <= AVS_WRITEDATA[`RSTC_CTRL_SCAN_MODE];
		end
	end

	// Request flops sit on the power-on reset so a system reset cannot clear them
	always_ff @(posedge REF_CLK)
	begin
		if (rst_q[IDX_POR]) // R7
		begin
			debug_port_off_flop_q    <= 1'b0;
			debug_port_enable_flop_q <= 1'b0;
			debug_core_reset_req_q   <= 1'b0;
			debug_micro_reset_req_q  <= 1'b0;
			debug_system_reset_req_q <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			debug_port_off_flop_q    <= AVS_WRITEDATA[`RSTC_CTRL_PORT_OFF];
			debug_port_enable_flop_q <= AVS_WRITEDATA[`RSTC_CTRL_PORT_EN];
			debug_core_reset_req_q   <= AVS_WRITEDATA[`RSTC_CTRL_CORE_REQ];
			debug_micro_reset_req_q  <= AVS_WRITEDATA[`RSTC_CTRL_MICRO_REQ];
			debug_system_reset_req_q <= AVS_WRITEDATA[`RSTC_CTRL_SYS_REQ];
		end
	end

	// Delayed copy of the routine-active flag extends the core mask by one clock
	always_ff @(posedge REF_CLK)
	begin
		if (rst_q[IDX_POR])
			active_q <= 1'b0;
		else
			active_q <= DEBUG_ACTIVE; // R15
	end

	assign scan_mode = debug_scan_mode_flop_q & SCAN_EN;
	assign core_mask = DEBUG_ACTIVE | active_q; // R14 R15

	always_comb
	begin
		rst_d[IDX_RAW]   = raw_sync; // R3
		rst_d[IDX_SCAN]  = scan_rst; // R5
		rst_d[IDX_POR]   = raw_sync; // R6
		rst_d[IDX_DPORT] = raw_sync | debug_port_off_flop_q | !debug_port_enable_flop_q; // R9
		rst_d[IDX_FSM]   = rst_d[IDX_DPORT] | DEBUG_FSM_RESET_REQ; // R10
		rst_d[IDX_SYS]   = raw_sync | debug_system_reset_req_q; // R11
		rst_d[IDX_MICRO] = rst_d[IDX_SYS] | debug_micro_reset_req_q; // R12
		rst_d[IDX_CORE]  = rst_d[IDX_MICRO] | (debug_core_reset_req_q & !core_mask); // R13 R14
		if (scan_mode)
			rst_d[IDX_CORE:IDX_POR] = {6{scan_rst}}; // R6 R16
	end

	// Outputs set asynchronously, released on a clock edge; consumers use them synchronously
	always_ff @(posedge REF_CLK or posedge ANALOG_RESET)
	begin
		if (ANALOG_RESET) // R1 R8
		begin
			rst_q   <= 8'hFF;
			rst_n_q <= 4'h0;
		end
		else
		begin
			rst_q   <= rst_d; // R2 R17
			rst_n_q <= ~{rst_d[IDX_CORE], rst_d[IDX_MICRO], rst_d[IDX_SYS], rst_d[IDX_POR]}; // R16
		end
	end

	assign AVS_WAITREQUEST = waitreq_q;
	assign AVS_READDATA    = readdata_q;
	assign RAW_RST         = rst_q[IDX_RAW];
	assign SCAN_RST        = rst_q[IDX_SCAN];
	assign POR_RST         = rst_q[IDX_POR];
	assign DEBUG_PORT_RST  = rst_q[IDX_DPORT];
	assign DEBUG_FSM_RST   = rst_q[IDX_FSM];
	assign SYS_RST         = rst_q[IDX_SYS];
	assign MICRO_RST       = rst_q[IDX_MICRO];
	assign CORE_RST        = rst_q[IDX_CORE];
	assign POR_RST_N       = rst_n_q[0];
	assign SYS_RST_N       = rst_n_q[1];
	assign MICRO_RST_N     = rst_n_q[2];
	assign CORE_RST_N      = rst_n_q[3];

	// Checks on the reset tree and the Avalon handshake

	property p_analog_all;
		@(posedge REF_CLK) disable iff (!RST_B)
		ANALOG_RESET |-> (rst_q == 8'hFF) && (rst_n_q == 4'h0);
	endproperty
	a_analog_all: assert property (p_analog_all) // R1
		else $error("Analog reset did not assert every reset");

	property p_release_sync;
		@(posedge REF_CLK) disable iff (!RST_B)
		ANALOG_RESET |=> rst_q[IDX_RAW] [*3];
	endproperty
	a_release_sync: assert property (p_release_sync) // R2
		else $error("Raw reset released before synchroniser delay");

	property p_forced_por;
		@(posedge REF_CLK) disable iff (!RST_B || ANALOG_RESET)
		$rose(debug_forced_por_flop_q) |-> ##[1:2] rst_q[IDX_RAW];
	endproperty
	a_forced_por: assert property (p_forced_por) // R3
		else $error("Forced power-on reset did not reach raw reset");

	property p_glitch_hold;
		@(posedge REF_CLK) disable iff (!RST_B || ANALOG_RESET)
		$fell(raw_sync) |-> $past(rst_q[IDX_RAW]) && !$past(debug_forced_por_flop_q);
	endproperty
	a_glitch_hold: assert property (p_glitch_hold) // R3
		else $error("Raw reset released while forced request was high");

	property p_scan_ctrl_clear;
		@(posedge REF_CLK) disable iff (!RST_B)
		rst_q[IDX_RAW] |=> !debug_forced_por_flop_q && !debug_scan_mode_flop_q;
	endproperty
	a_scan_ctrl_clear: assert property (p_scan_ctrl_clear) // R4
		else $error("Scan-control flops not cleared by raw reset");

	property p_scan_gate;
		@(posedge REF_CLK) disable iff (!RST_B)
		!SCAN_EN |=> !scan_rst;
	endproperty
	a_scan_gate: assert property (p_scan_gate) // R5
		else $error("Scan reset active without scan enable");

	property p_por_source;
		@(posedge REF_CLK) disable iff (!RST_B || ANALOG_RESET)
		1'b1 |=> rst_q[IDX_POR] == $past(scan_mode ? scan_rst : raw_sync);
	endproperty
	a_por_source: assert property (p_por_source) // R6
		else $error("Power-on reset does not follow its source");

	property p_port_disabled;
		@(posedge REF_CLK) disable iff (!RST_B || ANALOG_RESET)
		(!scan_mode && (debug_port_off_flop_q || !debug_port_enable_flop_q))
			|=> rst_q[IDX_DPORT] && rst_q[IDX_FSM];
	endproperty
	a_port_disabled: assert property (p_port_disabled) // R9
		else $error("Disabled debug port not held in reset");

	property p_fsm_only;
		@(posedge REF_CLK) disable iff (!RST_B || ANALOG_RESET)
		(DEBUG_FSM_RESET_REQ && !scan_mode && !rst_d[IDX_DPORT])
			|=> rst_q[IDX_FSM] && !rst_q[IDX_DPORT];
	endproperty
	a_fsm_only: assert property (p_fsm_only) // R10
		else $error("FSM request did not reset only the debug FSM");

	property p_sys_chain;
		@(posedge REF_CLK) disable iff (!RST_B || ANALOG_RESET)
		(debug_system_reset_req_q && !scan_mode)
			|=> rst_q[IDX_SYS] && rst_q[IDX_MICRO] && rst_q[IDX_CORE];
	endproperty
	a_sys_chain: assert property (p_sys_chain) // R11 R12 R13
		else $error("System request did not cascade downward");

	property p_micro_keeps_sys;
		@(posedge REF_CLK) disable iff (!RST_B || ANALOG_RESET)
		(debug_micro_reset_req_q && !scan_mode && !rst_d[IDX_SYS])
			|=> rst_q[IDX_MICRO] && rst_q[IDX_CORE] && !rst_q[IDX_SYS];
	endproperty
	a_micro_keeps_sys: assert property (p_micro_keeps_sys) // R12
		else $error("Micro request touched the system reset");

	property p_core_mask;
		@(posedge REF_CLK) disable iff (!RST_B || ANALOG_RESET)
		(debug_core_reset_req_q && DEBUG_ACTIVE && !rst_d[IDX_MICRO]) |=> !rst_q[IDX_CORE];
	endproperty
	a_core_mask: assert property (p_core_mask) // R14
		else $error("Core request not masked during secure routine");

	property p_core_delay;
		@(posedge REF_CLK) disable iff (!RST_B || ANALOG_RESET)
		($fell(DEBUG_ACTIVE) && debug_core_reset_req_q && !rst_d[IDX_MICRO])
			|=> !rst_q[IDX_CORE];
	endproperty
	a_core_delay: assert property (p_core_delay) // R15
		else $error("Core reset released mask too early");

	property p_low_copies;
		@(posedge REF_CLK) disable iff (!RST_B)
		rst_n_q == ~{rst_q[IDX_CORE], rst_q[IDX_MICRO], rst_q[IDX_SYS], rst_q[IDX_POR]};
	endproperty
	a_low_copies: assert property (p_low_copies) // R16
		else $error("Active-low copy disagrees with its reset");

	property p_scan_all;
		@(posedge REF_CLK) disable iff (!RST_B || ANALOG_RESET)
		scan_mode |=> rst_q[IDX_CORE:IDX_POR] == {6{$past(scan_rst)}};
	endproperty
	a_scan_all: assert property (p_scan_all) // R16
		else $error("Derived reset not replaced by scan reset");

	property p_bus_wait;
		@(posedge REF_CLK) disable iff (!RST_B)
		((AVS_READ || AVS_WRITE) && waitreq_q) |=> !waitreq_q ##1 waitreq_q;
	endproperty
	a_bus_wait: assert property (p_bus_wait) // Avalon handshake, an implementer's choice
		else $error("Waitrequest did not drop for exactly one cycle");

endmodule
`default_nettype wire

/* File: rstc_cfg.svh */
// Offsets, field positions, reset values and cycle counts of the reset controller.
// Included by every design module file of the block, not by the package; definitions only.
`ifndef RSTC_CFG_SVH
`define RSTC_CFG_SVH

// Avalon word byte addresses
`define RSTC_CTRL_OFS       4'h0
`define RSTC_STAT_OFS       4'h4

// Control word fields
`define RSTC_CTRL_FPOR      0
`define RSTC_CTRL_PORT_OFF  1
`define RSTC_CTRL_PORT_EN   2
`define RSTC_CTRL_CORE_REQ  4
`define RSTC_CTRL_MICRO_REQ 5
`define RSTC_CTRL_SYS_REQ   6
`define RSTC_CTRL_SCAN_MODE 7
`define RSTC_CTRL_RST       8'h00

// Status word fields
`define RSTC_STAT_RST_LSB   0
`define RSTC_STAT_ACTIVE    8
`define RSTC_STAT_SCAN      9

// Timing counts in REF_CLK cycles
`define RSTC_DEGLITCH_CYC   2
`define RSTC_SCAN_STAGES    3

`endif

/* File: rstc_pkg.sv */
// Types shared by the reset controller files.
// No assumptions beyond a SystemVerilog compiler.
package rstc_pkg;

	// Position of each reset in the registered reset vector
	typedef enum logic [2:0]
	{
		IDX_RAW   = 3'h0,
		IDX_SCAN  = 3'h1,
		IDX_POR   = 3'h2,
		IDX_DPORT = 3'h3,
		IDX_FSM   = 3'h4,
		IDX_SYS   = 3'h5,
		IDX_MICRO = 3'h6,
		IDX_CORE  = 3'h7
	} rst_idx_t;

	typedef logic [7:0] rst_vec_t;

endpackage

/* File: rst_deglitch_sync.sv */
// Synchroniser and low-pulse filter for the analog power-on reset.
// Assumes REF_CLK is running whenever the analog reset is released.
`timescale 1ns/1ps
`default_nettype none
`include "rstc_cfg.svh"
module rst_deglitch_sync
(
	input  wire logic clk,
	input  wire logic arst,
	input  wire logic force_rst,
	output var  logic rst_out
);
	logic       meta_q;
	logic       sync_q;
	logic [1:0] cnt_q;
	logic       req;

	// Assertion is immediate; only the release waits for clock edges
	always_ff @(posedge clk or posedge arst)
	begin
		if (arst)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end
		else
		begin
			meta_q <= 1'b0;
			sync_q <= meta_q;
		end
	end

	assign req = sync_q | force_rst;

	// A short low dip of the request does not release the output
	always_ff @(posedge clk or posedge arst)
	begin
		if (arst)
		begin
			cnt_q   <= 2'h0;
			rst_out <= 1'b1;
		end
		else if (req)
		begin
			cnt_q   <= 2'h0;
			rst_out <= 1'b1;
		end
		else if (cnt_q == 2'(`RSTC_DEGLITCH_CYC - 1))
			rst_out <= 1'b0;
		else
			cnt_q <= cnt_q + 2'h1;
	end

endmodule
`default_nettype wire

/* File: scan_rst_gen.sv */
// Scan reset generator: a short flop chain fed by the scan input.
// Assumes the raw reset is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "rstc_cfg.svh"
module scan_rst_gen
(
	input  wire logic clk,
	input  wire logic raw_rst,
	input  wire logic scan_en,
	input  wire logic scan_in,
	output var  logic scan_rst
);
	logic [`RSTC_SCAN_STAGES-1:0] chain_q;

	// Chain only moves under scan enable, so functional mode leaves it idle
	always_ff @(posedge clk)
	begin
		if (raw_rst)
			chain_q <= '1;
		else if (scan_en)
			chain_q <= {chain_q[`RSTC_SCAN_STAGES-2:0], scan_in};
	end

	always_ff @(posedge clk)
	begin
		if (raw_rst)
			scan_rst <= 1'b0;
		else
			scan_rst <= scan_en & chain_q[`RSTC_SCAN_STAGES-1];
	end

endmodule
`default_nettype wire

/* File: por_debug_model.sv */
// Far-side model: analog power-on reset source and the debug-side request levels.
// Assumes the bench drives its request inputs by non-blocking assignment at REF_CLK edges.
`timescale 1ns/1ps
`default_nettype none
module por_debug_model
#(
	parameter int HOLD = 2
)
(
	input  wire logic clk,
	input  wire logic por_req,
	input  wire logic boot_req,
	input  wire logic led_req,
	output var  logic analog_reset,
	output var  logic boot_active,
	output var  logic fsm_req
);
	logic [3:0] hold_q;

	// A supply monitor never drops its reset at once, so the release lags the request
	always_ff @(posedge clk)
	begin
		if (por_req)
			hold_q <= 4'(HOLD);
		else if (hold_q != 4'h0)
			hold_q <= hold_q - 4'h1;
	end

	// Reset rises with the request itself, not with a clock
	always_comb
	begin
		analog_reset = por_req | (hold_q != 4'h0);
		boot_active  = boot_req;
		fsm_req      = led_req;
	end
endmodule
`default_nettype wire

/* File: digital_reset_controller_bench.sv */
// Self-checking bench for the reset controller: a table of control settings, then edge cases.
// Assumes the design files and por_debug_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module digital_reset_controller_bench;
	import rstc_pkg::*;
	typedef struct packed {logic [7:0] ctrl; logic led; logic boot; logic [9:0] stat;} row_t;
	logic        clk, rst_b, por_req, boot_req, led_req, scan_en, scan_in, rd, wr, wait_req;
	logic [3:0]  addr, be;
	logic [31:0] wdata, rdata, q;
	wire         ana, act, fsm;
	wire  [7:0]  pins;
	wire  [3:0]  pins_n;
	int          num_errors, n_compared, i, n;
	row_t        rows [8] = '{
		{8'h04, 1'b0, 1'b0, 10'h000}, {8'h06, 1'b0, 1'b0, 10'h018},
		{8'h00, 1'b0, 1'b0, 10'h018}, {8'h0C, 1'b1, 1'b0, 10'h010},
		{8'h44, 1'b0, 1'b0, 10'h0E0}, {8'h24, 1'b0, 1'b0, 10'h0C0},
		{8'h14, 1'b0, 1'b0, 10'h080}, {8'h14, 1'b0, 1'b1, 10'h100}};

	por_debug_model model (.clk(clk), .por_req(por_req), .boot_req(boot_req), .led_req(led_req),
		.analog_reset(ana), .boot_active(act), .fsm_req(fsm));

	digital_reset_controller dut (.REF_CLK(clk), .RST_B(rst_b), .ANALOG_RESET(ana),
		.SCAN_EN(scan_en), .SCAN_IN(scan_in), .DEBUG_ACTIVE(act), .DEBUG_FSM_RESET_REQ(fsm),
		.AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
		.AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
		.RAW_RST(pins[0]), .SCAN_RST(pins[1]), .POR_RST(pins[2]), .DEBUG_PORT_RST(pins[3]),
		.DEBUG_FSM_RST(pins[4]), .SYS_RST(pins[5]), .MICRO_RST(pins[6]), .CORE_RST(pins[7]),
		.POR_RST_N(pins_n[0]), .SYS_RST_N(pins_n[1]), .MICRO_RST_N(pins_n[2]),
		.CORE_RST_N(pins_n[3]));

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic guard(input int k);
		if (k > 20)
		begin
			num_errors++;
			report_and_stop();
		end
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge clk);
	endtask

	// Values are read right after the edge, so they are those the edge sampled
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		while (wait_req !== 1'b0)
		begin
			k++;
			guard(k);
			@(posedge clk);
		end
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wait_bit(input logic which, input logic v);
		n = 0;
		while ((which ? ana : pins[0]) !== v)
		begin
			n++;
			guard(n);
			@(posedge clk);
		end
	endtask

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		num_errors = 0;
		n_compared = 0;
		rst_b = 1'b0;
		por_req = 1'b1;
		{boot_req, led_req, scan_en, scan_in, rd, wr} = 6'h00;
		addr = 4'h0;
		be = 4'hF;
		wdata = 32'h0000_0000;
		tick(3);
		chk(32'(wait_req), 32'h1);
		chk(rdata, 32'h0000_0000);
		chk(32'({pins_n, pins}), 32'h0000_00FF);
		rst_b <= 1'b1;
		por_req <= 1'b0;
		wait_bit(1'b1, 1'b0);
		wait_bit(1'b0, 1'b0);
		chk(32'(n >= 2), 32'h1);
		tick(2);
		chk(32'(pins), 32'h18);

		for (i = 0; i < 8; i++)
		begin
			led_req <= rows[i].led;
			boot_req <= rows[i].boot;
			bus(1'b1, 4'h0, 32'(rows[i].ctrl));
			tick(3);
			chk(32'(pins), 32'(rows[i].stat[7:0]));
			chk(32'(pins_n ^ {rows[i].stat[7:5], rows[i].stat[2]}), 32'hF);
			bus(1'b0, 4'h4, 32'h0000_0000);
			chk(32'(q[9:0]), 32'(rows[i].stat));
			bus(1'b0, 4'h0, 32'h0000_0000);
			chk(q, 32'(rows[i].ctrl & 8'hF7));
		end

		boot_req <= 1'b0;
		tick(1);
		chk(32'(pins[7]), 32'h0);
		tick(1);
		chk(32'(pins[7]), 32'h0);
		tick(2);
		chk(32'(pins[7]), 32'h1);

		bus(1'b1, 4'h8, 32'hFFFF_FFFF);
		bus(1'b0, 4'h8, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		be <= 4'h0;
		bus(1'b1, 4'h0, 32'h0000_0044);
		be <= 4'hF;
		bus(1'b0, 4'h0, 32'h0000_0000);
		chk(q, 32'h0000_0014);

		bus(1'b1, 4'h0, 32'h0000_0005);
		wait_bit(1'b0, 1'b1);
		tick(1);
		chk(32'(pins[2]), 32'h1);
		chk(32'(pins[5]), 32'h1);
		wait_bit(1'b0, 1'b0);
		tick(2);
		bus(1'b0, 4'h0, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		chk(32'(pins), 32'h18);

		bus(1'b1, 4'h0, 32'h0000_0084);
		scan_en <= 1'b1;
		tick(6);
		chk(32'(pins), 32'h00);
		bus(1'b0, 4'h4, 32'h0000_0000);
		chk(32'(q[9:8]), 32'h2);
		scan_in <= 1'b1;
		tick(6);
		chk(32'(pins), 32'hFE);
		scan_in <= 1'b0;
		scan_en <= 1'b0;
		tick(6);
		chk(32'(pins), 32'h18);
		bus(1'b0, 4'h0, 32'h0000_0000);
		chk(q, 32'h0000_0080);

		// Raised mid-run so the tree is seen to set before any further edge
		por_req <= 1'b1;
		#2;
		chk(32'({pins_n, pins}), 32'h0000_00FF);
		@(posedge clk);
		por_req <= 1'b0;
		wait_bit(1'b1, 1'b0);
		wait_bit(1'b0, 1'b0);
		chk(32'(n >= 2), 32'h1);
		tick(2);
		bus(1'b0, 4'h0, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		report_and_stop();
	end
endmodule
`default_nettype wire
